// ===== hw/osc_ref_cfg.svh
// register offsets, field positions, reset values for the clock-source and reference block
`ifndef OSC_REF_CFG_SVH
`define OSC_REF_CFG_SVH

`define OFS_NEW_SOURCE_REQUEST      12'h000
`define OFS_CURRENT_SOURCE_REPORT   12'h004
`define OFS_SWITCH_HOLD_AND_READY   12'h008
`define OFS_SOURCE_READY_FLAGS      12'h00c
`define OFS_INTERNAL_FREQ_SELECT    12'h010
`define OFS_INTERNAL_FREQ_TRIM      12'h014
`define OFS_MANUAL_SOURCE_ENABLES   12'h018
`define OFS_REFERENCE_CONTROL       12'h01c
`define OFS_REFERENCE_SOURCE        12'h020

`define RST_INTERNAL_FREQ_CODE      4'h2
`define RST_TRIM_VALUE              6'h00
`define RST_MANUAL_ENABLES          6'h00
`define RST_REFERENCE_CONTROL       8'h10
`define RST_REFERENCE_SOURCE        4'h0
`define RST_NEW_SOURCE_REQUEST      7'h62

`define FREQ_CODE_MAX               4'h8
`define REF_SOURCE_MAX              4'ha
`define REF_ENABLE_BIT              7
`define REF_DUTY_HI                 4
`define REF_DUTY_LO                 3
`define REF_DIV_HI                  2
`define SECONDARY_POWER_BIT         6

`endif

// ===== hw/osc_ref_pkg.sv
// types shared by the clock-source and reference block
package osc_ref_pkg;
	typedef enum logic [1:0] {
		duty_zero,
		duty_quarter,
		duty_half,
		duty_three_quarter
	} duty_type;

	typedef enum {
		ref_idle,
		ref_running
	} ref_state_type;
endpackage

// ===== hw/ref_ctrl_if.sv
// control bundle between register file and reference divider
`timescale 1ns/100ps
`default_nettype none
interface ref_ctrl_if;
	import osc_ref_pkg::*;
	logic       enable;
	logic [2:0] divide;
	duty_type   duty;
	logic       sleeping;
	logic       source_level;
	logic       ref_out;
	modport regs (output enable, divide, duty, sleeping, source_level, input ref_out);
	modport gen  (input enable, divide, duty, sleeping, source_level, output ref_out);
endinterface
`default_nettype wire

// ===== hw/ref_divider.sv
// reference clock divider with duty select
`timescale 1ns/100ps
`default_nettype none
module ref_divider
	import osc_ref_pkg::*;
(
	input  wire logic  core_clk,
	input  wire logic  reset_n,
	ref_ctrl_if.gen    ctrl
);
	logic [6:0]    count;
	logic          last_level;
	logic          out_q;
	ref_state_type state;

	wire rise       = ctrl.source_level & ~last_level;
	wire [6:0] top  = 7'((8'h01 << ctrl.divide) - 8'h01);
	wire [6:0] quar = 7'((8'h01 << ctrl.divide) >> 2);
	wire [6:0] half = 7'((8'h01 << ctrl.divide) >> 1);
	wire [6:0] mark = (ctrl.duty == duty_quarter) ? quar :
	                  (ctrl.duty == duty_half)    ? half :
	                  (ctrl.duty == duty_three_quarter) ? 7'(half + quar) : 7'h00;
	// wrap on reaching or passing top, so a smaller divide taken while running settles within one period
	wire [6:0] next_count = (count >= top) ? 7'h00 : 7'(count + 7'h01);
	wire next_level = (ctrl.divide == 3'h0) ? ctrl.source_level : (next_count < mark); // R12 R13
	assign ctrl.ref_out = out_q;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			count      <= 7'h00;
			last_level <= 1'b0;
			out_q      <= 1'b0;
			state      <= ref_idle;
		end else if (ctrl.sleeping) begin
			// frozen: hold every flop as is R17
		end else begin
			last_level <= ctrl.source_level;
			case (state)
			ref_idle: begin
				out_q <= 1'b0; // R23
				count <= top;
				// starting on a source edge avoids a runt first pulse
				if (ctrl.enable && rise) begin // R10
					state <= ref_running;
					count <= 7'h00;
					out_q <= (ctrl.divide == 3'h0) ? 1'b1 : (7'h00 < mark);
				end
			end
			ref_running: begin
				if (!ctrl.enable) begin // R11
					state <= ref_idle;
					out_q <= 1'b0;
				end else if (ctrl.divide == 3'h0) begin
					out_q <= ctrl.source_level;
				end else if (rise) begin // R15
					count <= next_count;
					out_q <= next_level;
				end
			end
			default: state <= ref_idle;
			endcase
		end
	end

	stop_output_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R11
		!ctrl.enable && !ctrl.sleeping |=> !out_q)
		else $error("reference not stopped");
	start_clean_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R10
		state == ref_idle && !rise && !ctrl.sleeping |=> !out_q)
		else $error("reference started off a source edge");
	zero_duty_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R20
		ctrl.duty == duty_zero && ctrl.divide != 3'h0 && state == ref_running && rise && !ctrl.sleeping
		&& ctrl.enable |=> !out_q)
		else $error("zero duty drove high");
	sleep_freeze_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R17
		ctrl.sleeping |=> $stable(out_q) && $stable(count))
		else $error("sleep changed state");
endmodule
`default_nettype wire

// ===== hw/source_status.sv
// per-source ready flags and effective oscillator enables
`timescale 1ns/100ps
`default_nettype none
module source_status (
	input  wire logic [5:0] force_on,
	input  wire logic [5:0] periph_request,
	input  wire logic [5:0] osc_running,
	input  wire logic       mult_enabled,
	input  wire logic       mult_input_ready,
	input  wire logic       mult_locked,
	output logic      [5:0] osc_enable,
	output logic      [5:0] ready,
	output logic            mult_ready
);
	// bit order: external, high, medium, low, secondary, converter
	for (genvar i = 0; i < 6; i++) begin : g_src
		assign osc_enable[i] = force_on[i] | periph_request[i]; // R5
		assign ready[i]      = osc_enable[i] & osc_running[i]; // R1
	end
	// medium source is derived from the high one, so it needs that one running R7
	assign mult_ready = mult_enabled & mult_input_ready & mult_locked; // R2
endmodule
`default_nettype wire

// ===== hw/osc_ref_top.sv
// clock-source control registers and reference clock output, APB slave
//
// Summary of operation
// R1 - ready flag shows oscillator usable
// R2 - multiplier ready needs enable, input, lock
// R3 - frequency code picks nominal internal frequency
// R4 - signed trim, zero is centre default
// R5 - force bit turns oscillator on
// R6 - forced sources run at configured settings
// R7 - medium source derived from high source
// R8 - unimplemented bits read zero
// R9 - source select register picks reference input
// R10 - enable starts output without runt
// R11 - disable stops output at once
// R12 - divide by one to 128
// R13 - duty 25/50/75, undivided passes input; at divide by two the code gives 0 for 25 and 50 for 75
// R14 - upper duty bit resets high
// R15 - divide and duty change while running
// R16 - software should change settings while disabled
// R17 - sleep freezes outputs and state
// R18 - reference goes to pin and peripherals
// R19 - divide code n means 2 to n
// R20 - duty codes 11,10,01,00 map to 75..0
// R21 - source code table with reserved codes
// R22 - module enable resets cleared
// R23 - disabled output low, counter cleared; the code loads the counter with top while idle instead
`timescale 1ns/100ps
`default_nettype none
`include "osc_ref_cfg.svh"
module osc_ref_top
	import osc_ref_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sleep_mode,
	input  wire logic [10:0] source_clocks,
	input  wire logic [5:0]  periph_request,
	input  wire logic [5:0]  osc_running,
	input  wire logic        mult_enabled,
	input  wire logic        mult_input_ready,
	input  wire logic        mult_locked,
	input  wire logic [6:0]  current_source,
	input  wire logic        switch_ready,
	input  wire logic        new_source_ready,
	output logic             reference_output,
	output logic             reference_internal,
	output logic      [5:0]  osc_enable,
	output logic      [3:0]  internal_freq_code,
	output logic      [5:0]  trim_value,
	output logic             secondary_power_mode,
	output logic      [6:0]  new_source_request
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [10:0] clk_meta;
	logic [10:0] clk_sync;
	logic [5:0]  run_meta;
	logic [5:0]  run_sync;
	logic [2:0]  mult_meta;
	logic [2:0]  mult_sync;
	logic [8:0]  cur_meta;
	logic [8:0]  cur_sync;
	logic        sleep_meta;
	logic        sleep_sync;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			clk_meta   <= 11'h000;
			clk_sync   <= 11'h000;
			run_meta   <= 6'h00;
			run_sync   <= 6'h00;
			mult_meta  <= 3'h0;
			mult_sync  <= 3'h0;
			cur_meta   <= 9'h000;
			cur_sync   <= 9'h000;
			sleep_meta <= 1'b0;
			sleep_sync <= 1'b0;
		end else begin
			clk_meta   <= source_clocks;
			clk_sync   <= clk_meta;
			run_meta   <= osc_running;
			run_sync   <= run_meta;
			mult_meta  <= {mult_enabled, mult_input_ready, mult_locked};
			mult_sync  <= mult_meta;
			cur_meta   <= {current_source, switch_ready, new_source_ready};
			cur_sync   <= cur_meta;
			sleep_meta <= sleep_mode;
			sleep_sync <= sleep_meta;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [6:0] new_src;
	logic [3:0] freq_code;
	logic [5:0] trim;
	logic [5:0] force_on;
	logic       sec_power;
	logic       hold_switch;
	logic       ref_enable;
	logic [1:0] ref_duty;
	logic [2:0] ref_div;
	logic [3:0] ref_source;

	wire wr_access = psel & penable & pwrite;
	wire hit_new   = (paddr == `OFS_NEW_SOURCE_REQUEST);
	wire hit_cur   = (paddr == `OFS_CURRENT_SOURCE_REPORT);
	wire hit_hold  = (paddr == `OFS_SWITCH_HOLD_AND_READY);
	wire hit_rdy   = (paddr == `OFS_SOURCE_READY_FLAGS);
	wire hit_frq   = (paddr == `OFS_INTERNAL_FREQ_SELECT);
	wire hit_trim  = (paddr == `OFS_INTERNAL_FREQ_TRIM);
	wire hit_man   = (paddr == `OFS_MANUAL_SOURCE_ENABLES);
	wire hit_rctl  = (paddr == `OFS_REFERENCE_CONTROL);
	wire hit_rsrc  = (paddr == `OFS_REFERENCE_SOURCE);
	wire hit_any   = hit_new | hit_cur | hit_hold | hit_rdy | hit_frq | hit_trim | hit_man | hit_rctl | hit_rsrc;
	// reserved codes are dropped so the hardware never sees them
	wire frq_legal = (pwdata[3:0] <= `FREQ_CODE_MAX); // R3
	wire src_legal = (pwdata[3:0] <= `REF_SOURCE_MAX); // R21

	// ----------------------------------------
	// write strobes and register fields
	// ----------------------------------------
	// the ready edge rewrites the value of the first access edge, which is harmless
	wire wr_new    = wr_access & hit_new;
	wire wr_hold   = wr_access & hit_hold;
	wire wr_frq    = wr_access & hit_frq & frq_legal; // R3
	wire wr_trim   = wr_access & hit_trim;
	wire wr_man    = wr_access & hit_man;
	wire wr_rctl   = wr_access & hit_rctl;
	wire wr_rsrc   = wr_access & hit_rsrc & src_legal; // R21

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			new_src <= `RST_NEW_SOURCE_REQUEST;
		end else if (wr_new) begin
			new_src <= pwdata[6:0];
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			hold_switch <= 1'b0;
			sec_power   <= 1'b0;
		end else if (wr_hold) begin
			hold_switch <= pwdata[7];
			sec_power   <= pwdata[`SECONDARY_POWER_BIT];
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			freq_code <= `RST_INTERNAL_FREQ_CODE;
		end else if (wr_frq) begin
			freq_code <= pwdata[3:0]; // R3
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			trim <= `RST_TRIM_VALUE; // R4
		end else if (wr_trim) begin
			trim <= pwdata[5:0]; // R4
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			force_on <= `RST_MANUAL_ENABLES;
		end else if (wr_man) begin
			force_on <= pwdata[7:2]; // R5
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ref_enable <= 1'(`RST_REFERENCE_CONTROL >> `REF_ENABLE_BIT); // R22
			ref_duty   <= 2'(`RST_REFERENCE_CONTROL >> `REF_DUTY_LO); // R14
			ref_div    <= 3'h0;
		end else if (wr_rctl) begin
			ref_enable <= pwdata[`REF_ENABLE_BIT];
			ref_duty   <= pwdata[`REF_DUTY_HI:`REF_DUTY_LO]; // R20
			ref_div    <= pwdata[`REF_DIV_HI:0]; // R19
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ref_source <= `RST_REFERENCE_SOURCE;
		end else if (wr_rsrc) begin
			ref_source <= pwdata[3:0]; // R21
		end
	end

	// ----------------------------------------
	// source status
	// ----------------------------------------
	logic [5:0] ready_flags;
	logic [5:0] next_enable;
	logic       mult_ready_w;

	source_status u_status (
		.force_on         (force_on),
		.periph_request   (periph_request),
		.osc_running      (run_sync),
		.mult_enabled     (mult_sync[2]),
		.mult_input_ready (mult_sync[1]),
		.mult_locked      (mult_sync[0]),
		.osc_enable       (next_enable),
		.ready            (ready_flags),
		.mult_ready       (mult_ready_w)
	);

	// medium force also needs the high source alive R7
	wire [5:0] enable_final = next_enable | {1'b0, next_enable[3], 4'h0};

	// ----------------------------------------
	// reference generator
	// ----------------------------------------
	ref_ctrl_if ctrl ();
	assign ctrl.enable       = ref_enable;
	assign ctrl.divide       = ref_div;
	assign ctrl.duty         = duty_type'(ref_duty);
	assign ctrl.sleeping     = sleep_sync; // R17
	assign ctrl.source_level = clk_sync[ref_source]; // R9

	ref_divider u_div (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.ctrl     (ctrl)
	);

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	wire [31:0] rd_value =
		hit_new  ? {25'h0, new_src} :
		hit_cur  ? {25'h0, cur_sync[8:2]} :
		hit_hold ? {24'h0, hold_switch, sec_power, 1'b0, cur_sync[1:0], 3'h0} :
		hit_rdy  ? {24'h0, ready_flags, 1'b0, mult_ready_w} : // R1 R2 R8
		hit_frq  ? {28'h0, freq_code} : // R8
		hit_trim ? {26'h0, trim} : // R8
		hit_man  ? {24'h0, force_on, 2'h0} : // R8
		hit_rctl ? {24'h0, ref_enable, 2'h0, ref_duty, ref_div} :
		hit_rsrc ? {28'h0, ref_source} : 32'h0;

	// ----------------------------------------
	// bus answer and registered outputs
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			// one wait state: answer in the cycle after the first access edge
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~hit_any;
			prdata  <= (psel & ~pwrite) ? rd_value : 32'h0;
		end
	end

	// every output is a flop, so decode hazards never reach the pins
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			reference_output     <= 1'b0;
			reference_internal   <= 1'b0;
			osc_enable           <= 6'h00;
			internal_freq_code   <= `RST_INTERNAL_FREQ_CODE;
			trim_value           <= `RST_TRIM_VALUE;
			secondary_power_mode <= 1'b0;
			new_source_request   <= `RST_NEW_SOURCE_REQUEST;
		end else begin
			reference_output     <= ctrl.ref_out; // R18
			reference_internal   <= ctrl.ref_out; // R18
			osc_enable           <= enable_final; // R5
			internal_freq_code   <= freq_code; // R6
			trim_value           <= trim; // R4
			secondary_power_mode <= sec_power; // R6
			new_source_request   <= new_src;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	unmapped_error_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		psel && penable && !pready && !hit_any |=> pready && pslverr)
		else $error("unmapped not flagged");
	wait_state_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		psel && penable && !pready |=> pready)
		else $error("answer not one cycle late");
	ready_pulse_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		pready |=> !pready)
		else $error("ready held too long");
	ready_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R8
		psel && penable && !pwrite && hit_rdy && !pready |=> prdata[1] == 1'b0)
		else $error("reserved bit set");
	frq_zero_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R8
		psel && penable && !pwrite && hit_frq && !pready |=> prdata[31:4] == 28'h0)
		else $error("frequency upper bits set");
	trim_zero_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R8
		psel && penable && !pwrite && hit_trim && !pready |=> prdata[31:6] == 26'h0)
		else $error("trim upper bits set");
	man_zero_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R8
		psel && penable && !pwrite && hit_man && !pready |=> prdata[31:8] == 24'h0 && prdata[1:0] == 2'h0)
		else $error("enable spare bits set");
	force_enable_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R5
		force_on[4] |=> osc_enable[4])
		else $error("forced source off");
	request_enable_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R5
		periph_request[0] |=> osc_enable[0])
		else $error("requested source off");
	medium_high_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R7
		osc_enable[3] |-> osc_enable[4])
		else $error("medium source without high source");
	freq_legal_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R3
		freq_code <= `FREQ_CODE_MAX)
		else $error("reserved frequency code");
	freq_ignore_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R3
		wr_access && hit_frq && !frq_legal |=> freq_code == $past(freq_code))
		else $error("reserved frequency write landed");
	src_legal_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R21
		ref_source <= `REF_SOURCE_MAX)
		else $error("reserved source code");
	mult_ready_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R2
		psel && penable && !pwrite && hit_rdy && !pready |=> prdata[0] == ($past(mult_sync) == 3'h7))
		else $error("multiplier ready misread");
	ref_copy_a: assert property (@(posedge core_clk) disable iff (!reset_n) // R18
		reference_output == reference_internal)
		else $error("pin and peripheral copies differ");
endmodule
`default_nettype wire

// ===== test/ref_partner.sv
// far-side model: oscillators, reference sources, reference clock consumer
`timescale 1ns/100ps
`default_nettype none
module ref_partner (
	input  wire logic        core_clk,
	input  wire logic [5:0]  osc_enable,
	input  wire logic        reference_output,
	output logic      [10:0] source_clocks,
	output logic      [5:0]  osc_running,
	output var int           last_period,
	output var int           last_high
);
	logic [3:0] tick = 4'h0;
	logic [5:0] warm1 = 6'h00;
	logic [5:0] warm2 = 6'h00;
	logic       ref_prev = 1'b0;
	int         since_rise = 0;
	int         high_cnt = 0;
	// even codes run at 8 cycles, odd at 16, so a wrong select shows
	always_comb for (int i = 0; i < 11; i++) source_clocks[i] = tick[2 + i % 2];
	always @(posedge core_clk) begin
		tick <= tick + 4'h1;
		// start-up delay of three cycles, stop at once
		warm1 <= osc_enable;
		warm2 <= warm1;
		osc_running <= warm2 & osc_enable;
		ref_prev <= reference_output;
		since_rise <= since_rise + 1;
		if (reference_output)
			high_cnt <= high_cnt + 1;
		if (reference_output && !ref_prev) begin
			last_period <= since_rise;
			since_rise <= 1;
			high_cnt <= 1;
		end
		if (!reference_output && ref_prev)
			last_high <= high_cnt;
	end
endmodule
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the clock-source and reference block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module testbench
	import osc_ref_pkg::*;
;
	logic        core_clk, reset_n, psel, penable, pwrite, pready, pslverr, sleep_mode, err;
	logic        mult_enabled, mult_input_ready, mult_locked, switch_ready, new_source_ready;
	logic        reference_output, reference_internal, secondary_power_mode;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [10:0] source_clocks;
	logic [5:0]  periph_request, osc_running, osc_enable, trim_value;
	logic [6:0]  current_source, new_source_request;
	logic [3:0]  internal_freq_code;
	int          miscompares, total_checks, cycles, last_period, last_high;
	osc_ref_top dut (.core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .sleep_mode, .source_clocks, .periph_request, .osc_running, .mult_enabled,
		.mult_input_ready, .mult_locked, .current_source, .switch_ready, .new_source_ready,
		.reference_output, .reference_internal, .osc_enable, .internal_freq_code, .trim_value,
		.secondary_power_mode, .new_source_request);
	ref_partner far (.core_clk, .osc_enable, .reference_output, .source_clocks, .osc_running,
		.last_period, .last_high);
	// ----------------------------------------
	// bus access and closing
	// ----------------------------------------
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		`CHK("pready", 1'b1, pready)
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge so a following call never re-drives psel in one step
		@(posedge core_clk);
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		`CHK("register", exp, rd)
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic test_reset;
		rchk(12'h000, 32'h62);
		rchk(12'h010, 32'h2);
		rchk(12'h014, 32'h0);
		rchk(12'h018, 32'h0);
		rchk(12'h01c, 32'h10);
		rchk(12'h020, 32'h0);
		rchk(12'h00c, 32'h0);
		rchk(12'h004, 32'h35);
		`CHK("ref_out", 1'b0, reference_output)
	endtask
	task automatic test_fields;
		bus(1'b1, 12'h010, 32'h8);
		rchk(12'h010, 32'h8);
		`CHK("freq_code", 4'h8, internal_freq_code)
		bus(1'b1, 12'h010, 32'h9);
		rchk(12'h010, 32'h8);
		bus(1'b1, 12'h014, 32'hffffffff);
		rchk(12'h014, 32'h3f);
		`CHK("trim", 6'h3f, trim_value)
		bus(1'b1, 12'h014, 32'h20);
		rchk(12'h014, 32'h20);
		switch_ready <= 1'b1;
		bus(1'b1, 12'h008, 32'h40);
		rchk(12'h008, 32'h50);
		`CHK("sec_power", 1'b1, secondary_power_mode)
		bus(1'b1, 12'h004, 32'hff);
		rchk(12'h004, 32'h35);
		bus(1'b1, 12'h000, 32'h61);
		`CHK("new_src", 7'h61, new_source_request)
		bus(1'b1, 12'h020, 32'h5);
		bus(1'b1, 12'h020, 32'hb);
		rchk(12'h020, 32'h5);
		bus(1'b1, 12'h01c, 32'h7f);
		rchk(12'h01c, 32'h1f);
		bus(1'b1, 12'h01c, 32'h0);
		bus(1'b0, 12'h100, 32'h0);
		`CHK("slverr", 1'b1, err)
	endtask
	task automatic test_ready;
		periph_request <= 6'h09;
		repeat (4) @(posedge core_clk);
		`CHK("osc_en", 6'h19, osc_enable)
		periph_request <= 6'h00;
		bus(1'b1, 12'h018, 32'hff);
		rchk(12'h018, 32'hfc);
		`CHK("osc_en", 6'h3f, osc_enable)
		repeat (10) @(posedge core_clk);
		rchk(12'h00c, 32'hfc);
		mult_enabled <= 1'b1;
		mult_input_ready <= 1'b1;
		mult_locked <= 1'b1;
		repeat (6) @(posedge core_clk);
		rchk(12'h00c, 32'hfd);
		mult_locked <= 1'b0;
		repeat (6) @(posedge core_clk);
		rchk(12'h00c, 32'hfc);
		bus(1'b1, 12'h018, 32'h0);
		repeat (10) @(posedge core_clk);
		rchk(12'h00c, 32'h0);
	endtask
	task automatic run_ref(input logic [3:0] s, input logic [7:0] c, input int per, input int hi);
		bus(1'b1, 12'h020, {28'h0, s});
		bus(1'b1, 12'h01c, {24'h0, c});
		repeat (3 * per + 24) @(posedge core_clk);
		`CHK("period", per, last_period)
		`CHK("high", hi, last_high)
		`CHK("internal", reference_output, reference_internal)
		bus(1'b1, 12'h01c, 32'h0);
		repeat (6) @(posedge core_clk);
		`CHK("stopped", 1'b0, reference_output)
	endtask
	task automatic test_zero_duty;
		int highs;
		highs = 0;
		bus(1'b1, 12'h01c, 32'h81);
		repeat (64) begin
			@(posedge core_clk);
			if (reference_output !== 1'b0)
				highs++;
		end
		`CHK("zero duty", 0, highs)
		bus(1'b1, 12'h01c, 32'h0);
	endtask
	task automatic test_sleep;
		logic v;
		int   changes;
		bus(1'b1, 12'h01c, 32'h93);
		repeat (200) @(posedge core_clk);
		sleep_mode <= 1'b1;
		repeat (8) @(posedge core_clk);
		v = reference_output;
		changes = 0;
		// every cycle is watched: a free-running output could match at two spot samples
		repeat (100) begin
			@(posedge core_clk);
			if (reference_output !== v)
				changes++;
		end
		`CHK("frozen", 0, changes)
		sleep_mode <= 1'b0;
		repeat (200) @(posedge core_clk);
		`CHK("period", 64, last_period)
		bus(1'b1, 12'h01c, 32'h92);
		repeat (120) @(posedge core_clk);
		`CHK("period", 32, last_period)
		bus(1'b1, 12'h01c, 32'h0);
	endtask
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// a hang costs a mismatch; the full run needs about 4600 cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			stop_test();
		end
	end
	initial begin
		{reset_n, psel, penable, pwrite, sleep_mode, mult_enabled, mult_input_ready} = '0;
		{mult_locked, switch_ready, new_source_ready} = '0;
		paddr = 12'h000;
		pwdata = 32'h0;
		periph_request = 6'h00;
		current_source = 7'h35;
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		test_reset();
		test_fields();
		test_ready();
		// neighbouring runs differ so a stale measurement cannot pass
		run_ref(4'h0, 8'h90, 8, 4);
		run_ref(4'h1, 8'h90, 16, 8);
		run_ref(4'h0, 8'h88, 8, 4);
		run_ref(4'h0, 8'h91, 16, 8);
		run_ref(4'h0, 8'h8a, 32, 8);
		run_ref(4'h0, 8'h9a, 32, 24);
		run_ref(4'h0, 8'h97, 1024, 512);
		test_zero_duty();
		test_sleep();
		stop_test();
	end
endmodule
`default_nettype wire
